// File: vram_host_defines.vh
// Purpose: Named constants for the video DRAM host controller.
// Assumes: A 100 MHz controller clock and a 32-bit Avalon-MM register port.
// Notes: Byte offsets, field positions, command codes and timing figures.
`ifndef VRAM_HOST_DEFINES_VH
`define VRAM_HOST_DEFINES_VH

`define CLK_PERIOD_NS 10
`define STROBE_PHASE_NS 60
`define STROBE_PHASE_CYC ((`STROBE_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHIFT_HALF_NS 40
`define SHIFT_HALF_CYC ((`SHIFT_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPLIT_GUARD 8'h04

`define OFF_CMD 5'h00
`define OFF_ADDR 5'h04
`define OFF_DATA 5'h08
`define OFF_STATUS 5'h0c
`define OFF_SERIAL 5'h10
`define OFF_MASK 5'h14

`define ROW_LSB 0
`define COL_LSB 16
`define ST_BUSY 0
`define ST_HALF 1
`define ST_PRIMED 2
`define ST_REFUSED 3

`define OP_FULL_XFER 4'h0
`define OP_SPLIT_XFER 4'h1
`define OP_STOP_SET 4'h2
`define OP_OPT_RESET 4'h3
`define OP_PLAIN_REF 4'h4
`define OP_NORMAL_WR 4'h5
`define OP_MASKED_WR 4'h6
`define OP_BLOCK_WR 4'h7
`define OP_MBLOCK_WR 4'h8
`define OP_LOAD_MASK 4'h9
`define OP_LOAD_COLOR 4'ha

`define STOP_1X256 4'hf
`define STOP_2X128 4'h7
`define STOP_4X64 4'h3
`define STOP_8X32 4'h1
`define STOP_16X16 4'h0

`define HALF_LAST 8'hff

`endif

// File: vram_host.v
// Purpose: Host controller that drives a split-transfer video DRAM through its pins.
// Assumes: Software issues commands over Avalon-MM; the serial clock is made here.
// Notes: One command runs at a time; the serial clock runs independently of it.
// Notes on behaviour
// - Controller refuses any split read transfer until a full read transfer has run.
// - Split transfer: select and write strobe high, transfer strobe low at row fall.
// - Row latched at row fall; column bits 0-7 give tap, top bit ignored.
// - Controller avoids split transfers in the window around a half boundary.
// - Stop-set refresh: column-first, write strobe low, select high; row gives code.
// - Column-first refresh: column strobe low before row strobe falls.
`timescale 1ns/1ps
`default_nettype none
`include "vram_host_defines.vh"

module vram_host #(
    parameter PHASE_CYC = `STROBE_PHASE_CYC,
    parameter SHIFT_HALF = `SHIFT_HALF_CYC
) (
    input wire mclk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire [4:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    output reg ras_n_o,
    output reg cas_n_o,
    output reg transfer_output_enable_n_o,
    output reg write_mask_strobe_n_o,
    output reg special_function_select_o,
    output reg [8:0] addr_o,
    output reg [15:0] dq_o,
    output reg dq_oe_o,
    input wire [15:0] dq_i,
    output reg serial_shift_clock_o,
    output reg serial_port_enable_n_o,
    input wire serial_half_indicator_i
);
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_RAS = 3'h2;
    localparam S_CAS = 3'h3;
    localparam S_HOLD = 3'h4;
    localparam S_PRE = 3'h5;

    reg [2:0] state_ff;
    reg [7:0] timer_ff;
    reg [3:0] op_ff;
    reg pending_ff;
    reg [8:0] row_ff;
    reg [8:0] col_ff;
    reg [15:0] data_ff;
    reg [15:0] mask_ff;
    reg primed_ff;
    reg refused_ff;
    reg [15:0] shift_left_ff;
    reg [7:0] shift_timer_ff;
    reg [8:0] saddr_ff;
    reg [7:0] split_tap_ff;
    reg split_armed_ff;
    reg half_meta_ff;
    reg half_sync_ff;
    reg [15:0] dq_meta_ff;
    reg [15:0] dq_sync_ff;

    wire is_split = (op_ff == `OP_SPLIT_XFER);
    wire is_xfer = (op_ff == `OP_FULL_XFER) || is_split;
    wire is_ref = (op_ff == `OP_STOP_SET) || (op_ff == `OP_OPT_RESET) ||
                  (op_ff == `OP_PLAIN_REF);
    wire is_block = (op_ff == `OP_BLOCK_WR) || (op_ff == `OP_MBLOCK_WR);
    wire is_masked = (op_ff == `OP_MASKED_WR) || (op_ff == `OP_MBLOCK_WR);
    // Write strobe and select levels at the row fall, select at the column fall.
    wire we_ras = !((op_ff == `OP_STOP_SET) || is_masked);
    wire sel_ras = is_split || (op_ff == `OP_STOP_SET) || (op_ff == `OP_PLAIN_REF) ||
                   (op_ff == `OP_LOAD_MASK) || (op_ff == `OP_LOAD_COLOR);
    wire sel_cas = is_block || (op_ff == `OP_LOAD_COLOR);
    wire [3:0] stop_code = row_ff[7:4];
    wire stop_ok = (stop_code == `STOP_1X256) || (stop_code == `STOP_2X128) ||
                   (stop_code == `STOP_4X64) || (stop_code == `STOP_8X32) ||
                   (stop_code == `STOP_16X16);
    // A split near the end or start of a half could race the device's boundary jump.
    wire in_window = (saddr_ff[7:0] >= (`HALF_LAST - `SPLIT_GUARD)) ||
                     (saddr_ff[7:0] <= `SPLIT_GUARD);
    wire bus_req = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    wire cmd_wr = avs_write_i && (avs_address_i == `OFF_CMD);
    wire can_take = !(cmd_wr && pending_ff);
    wire accept = bus_req && can_take;
    wire shift_rise = (shift_left_ff != 16'h0000) && (shift_timer_ff == 8'h00) &&
                      !serial_shift_clock_o;
    wire phase_done = (timer_ff == 8'h00);
    wire split_launch = (state_ff == S_RAS) && phase_done && is_split;
    wire refuse_now = (state_ff == S_IDLE) && pending_ff &&
                      ((is_split && !primed_ff) ||
                       ((op_ff == `OP_STOP_SET) && !stop_ok));

    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h00000000;
        case (avs_address_i)
            `OFF_CMD: rd_val = {28'h0000000, op_ff};
            `OFF_ADDR: rd_val = {7'h00, col_ff, 7'h00, row_ff};
            `OFF_DATA: rd_val = {dq_sync_ff, data_ff};
            `OFF_STATUS: rd_val = {28'h0000000, refused_ff, primed_ff, half_sync_ff,
                                   pending_ff};
            `OFF_SERIAL: rd_val = {7'h00, saddr_ff, shift_left_ff};
            `OFF_MASK: rd_val = {16'h0000, mask_ff};
            default: rd_val = 32'h00000000;
        endcase
    end

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h00000000;
            avs_waitrequest_o <= 1'b1;
            op_ff <= 4'h0;
            row_ff <= 9'h000;
            col_ff <= 9'h000;
            data_ff <= 16'h0000;
            mask_ff <= 16'h0000;
            pending_ff <= 1'b0;
            refused_ff <= 1'b0;
            shift_left_ff <= 16'h0000;
        end else if (ce_i) begin
            avs_waitrequest_o <= !accept;
            if (accept && avs_read_i) begin
                avs_readdata_o <= rd_val;
            end
            if (accept && avs_write_i) begin
                case (avs_address_i)
                    `OFF_CMD: op_ff <= avs_writedata_i[3:0];
                    `OFF_ADDR: begin
                        row_ff <= avs_writedata_i[`ROW_LSB +: 9];
                        col_ff <= avs_writedata_i[`COL_LSB +: 9];
                    end
                    `OFF_DATA: data_ff <= avs_writedata_i[15:0];
                    `OFF_MASK: mask_ff <= avs_writedata_i[15:0];
                    default: ;
                endcase
            end
            if (accept && cmd_wr) begin
                pending_ff <= 1'b1;
            end else if (refuse_now || (state_ff == S_PRE && phase_done)) begin
                pending_ff <= 1'b0;
            end
            // A refusal in the same cycle as the clear keeps the flag set.
            if (refuse_now) begin
                refused_ff <= 1'b1;
            end else if (accept && avs_write_i && avs_address_i == `OFF_STATUS &&
                         avs_writedata_i[`ST_REFUSED]) begin
                refused_ff <= 1'b0;
            end
            if (accept && avs_write_i && avs_address_i == `OFF_SERIAL) begin
                shift_left_ff <= avs_writedata_i[15:0];
            end else if (serial_shift_clock_o && shift_timer_ff == 8'h00 &&
                         shift_left_ff != 16'h0000) begin
                shift_left_ff <= shift_left_ff - 16'h0001;
            end
        end
    end

    // Serial clock and a shadow of the device's serial address counter.
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_shift_clock_o <= 1'b0;
            serial_port_enable_n_o <= 1'b1;
            shift_timer_ff <= 8'h00;
            saddr_ff <= 9'h000;
            split_tap_ff <= 8'h00;
            split_armed_ff <= 1'b0;
            half_meta_ff <= 1'b0;
            half_sync_ff <= 1'b0;
            dq_meta_ff <= 16'h0000;
            dq_sync_ff <= 16'h0000;
        end else if (ce_i) begin
            half_meta_ff <= serial_half_indicator_i;
            half_sync_ff <= half_meta_ff;
            dq_meta_ff <= dq_i;
            dq_sync_ff <= dq_meta_ff;
            // The split transfer never touches the serial port enable.
            serial_port_enable_n_o <= (shift_left_ff == 16'h0000);
            if (shift_left_ff != 16'h0000) begin
                if (shift_timer_ff == 8'h00) begin
                    serial_shift_clock_o <= !serial_shift_clock_o;
                    shift_timer_ff <= SHIFT_HALF[7:0] - 8'h01;
                end else begin
                    shift_timer_ff <= shift_timer_ff - 8'h01;
                end
            end else begin
                serial_shift_clock_o <= 1'b0;
                shift_timer_ff <= 8'h00;
            end
            if (state_ff == S_RAS && phase_done && op_ff == `OP_FULL_XFER) begin
                saddr_ff <= col_ff;
                split_armed_ff <= 1'b0;
            end else if (shift_rise && saddr_ff[7:0] == `HALF_LAST) begin
                if (split_armed_ff) begin
                    saddr_ff <= {!saddr_ff[8], split_tap_ff};
                    split_armed_ff <= 1'b0;
                end else begin
                    saddr_ff <= saddr_ff + 9'h001;
                end
            end else if (shift_rise) begin
                saddr_ff <= saddr_ff + 9'h001;
            end
            if (split_launch) begin
                split_tap_ff <= col_ff[7:0];
                split_armed_ff <= 1'b1;
            end
        end
    end

    // Strobe sequencer: setup, row fall, column fall, hold, precharge.
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= S_IDLE;
            timer_ff <= 8'h00;
            primed_ff <= 1'b0;
            ras_n_o <= 1'b1;
            cas_n_o <= 1'b1;
            transfer_output_enable_n_o <= 1'b1;
            write_mask_strobe_n_o <= 1'b1;
            special_function_select_o <= 1'b0;
            addr_o <= 9'h000;
            dq_o <= 16'h0000;
            dq_oe_o <= 1'b0;
        end else if (ce_i) begin
            if (!phase_done) begin
                timer_ff <= timer_ff - 8'h01;
            end
            case (state_ff)
                S_IDLE: begin
                    if (pending_ff && !refuse_now && !(is_split && in_window)) begin
                        state_ff <= S_SETUP;
                        timer_ff <= PHASE_CYC[7:0] - 8'h01;
                        addr_o <= row_ff;
                        cas_n_o <= !is_ref;
                        transfer_output_enable_n_o <= !is_xfer;
                        write_mask_strobe_n_o <= we_ras;
                        special_function_select_o <= sel_ras;
                        dq_o <= mask_ff;
                        dq_oe_o <= is_masked;
                    end
                end
                S_SETUP: if (phase_done) begin
                    state_ff <= S_RAS;
                    timer_ff <= PHASE_CYC[7:0] - 8'h01;
                    ras_n_o <= 1'b0;
                end
                S_RAS: if (phase_done) begin
                    timer_ff <= PHASE_CYC[7:0] - 8'h01;
                    dq_oe_o <= 1'b0;
                    if (op_ff == `OP_FULL_XFER) begin
                        primed_ff <= 1'b1;
                    end
                    if (is_ref) begin
                        state_ff <= S_HOLD;
                    end else begin
                        state_ff <= S_CAS;
                        cas_n_o <= 1'b0;
                        special_function_select_o <= sel_cas;
                        transfer_output_enable_n_o <= 1'b1;
                        if (is_split) begin
                            addr_o <= {1'b0, col_ff[7:0]};
                        end else if (is_block) begin
                            addr_o <= {col_ff[8:3], 3'h0};
                        end else begin
                            addr_o <= col_ff;
                        end
                        if (!is_xfer) begin
                            write_mask_strobe_n_o <= 1'b0;
                            dq_o <= data_ff;
                            dq_oe_o <= 1'b1;
                        end
                    end
                end
                S_CAS: if (phase_done) begin
                    state_ff <= S_HOLD;
                    timer_ff <= PHASE_CYC[7:0] - 8'h01;
                end
                S_HOLD: if (phase_done) begin
                    state_ff <= S_PRE;
                    timer_ff <= PHASE_CYC[7:0] - 8'h01;
                    ras_n_o <= 1'b1;
                    cas_n_o <= 1'b1;
                    transfer_output_enable_n_o <= 1'b1;
                    write_mask_strobe_n_o <= 1'b1;
                    special_function_select_o <= 1'b0;
                    dq_oe_o <= 1'b0;
                end
                S_PRE: if (phase_done) begin
                    state_ff <= S_IDLE;
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: vram_host_monitor.sv
// Purpose: Pin and bus checker for the video DRAM host.
// Assumes: Bound to vram_host with its SHIFT_HALF.
// Notes: Helper flops keep the levels seen at the last row fall.
`timescale 1ns/1ps
`default_nettype none
module vram_host_monitor #(
    parameter SHIFT_HALF = 4
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic avs_waitrequest_o,
    input wire logic ras_n_o,
    input wire logic cas_n_o,
    input wire logic transfer_output_enable_n_o,
    input wire logic write_mask_strobe_n_o,
    input wire logic special_function_select_o,
    input wire logic [8:0] addr_o,
    input wire logic dq_oe_o,
    input wire logic serial_shift_clock_o
);
    logic [7:0] shift_hi_ff;
    logic ras_q_ff;
    logic xfer_ff;
    logic selr_ff;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_hi_ff <= 8'h00;
            ras_q_ff <= 1'b1;
            xfer_ff <= 1'b0;
            selr_ff <= 1'b0;
        end else begin
            ras_q_ff <= ras_n_o;
            shift_hi_ff <= serial_shift_clock_o ? shift_hi_ff + 8'h01 : 8'h00;
            if (ras_q_ff && !ras_n_o) begin
                xfer_ff <= !transfer_output_enable_n_o;
                selr_ff <= special_function_select_o;
            end
        end
    end
    a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest held low");
    a_transfer_we_high: assert property ($fell(ras_n_o) && cas_n_o &&
        !transfer_output_enable_n_o |-> write_mask_strobe_n_o) else $error("transfer, we low");
    a_cas_before_ras: assert property ($fell(ras_n_o) && !cas_n_o |-> !$past(cas_n_o))
        else $error("refresh without column setup");
    a_split_tap_msb: assert property ($fell(cas_n_o) && !ras_n_o && xfer_ff && selr_ff
        |-> !addr_o[8]) else $error("split tap top bit set");
    a_block_col_low: assert property ($fell(cas_n_o) && !ras_n_o && !xfer_ff && !selr_ff &&
        special_function_select_o |-> addr_o[2:0] == 3'h0) else $error("block column bits");
    a_new_mask_dq: assert property ($fell(ras_n_o) && cas_n_o && transfer_output_enable_n_o &&
        !write_mask_strobe_n_o && !special_function_select_o |-> dq_oe_o) else $error("no mask");
    a_stop_code_legal: assert property ($fell(ras_n_o) && !cas_n_o && !write_mask_strobe_n_o &&
        special_function_select_o |-> addr_o[7:4] inside {4'hf, 4'h7, 4'h3, 4'h1, 4'h0})
        else $error("illegal stop code");
    a_shift_high_len: assert property ($fell(serial_shift_clock_o) |-> shift_hi_ff == SHIFT_HALF)
        else $error("serial clock high time");
    c_split: cover property ($fell(cas_n_o) && !ras_n_o && xfer_ff && selr_ff);
    c_block: cover property ($fell(cas_n_o) && !ras_n_o && !selr_ff && special_function_select_o);
    c_refresh: cover property ($fell(ras_n_o) && !cas_n_o);
endmodule
`default_nettype wire

// File: vram_dev_model.sv
// Purpose: Behavioural split-transfer video DRAM seen from its pins.
// Assumes: Strobes are active low; the host makes the serial clock.
// Notes: Only the serial pointer, the pending split tap and the stop register are kept.
`timescale 1ns/1ps
`default_nettype none
module vram_dev_model (
    input wire logic mclk_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic xfer_n_i,
    input wire logic we_n_i,
    input wire logic sel_i,
    input wire logic [8:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic dq_oe_i,
    input wire logic shift_clk_i,
    output logic half_o,
    output logic [15:0] dq_o
);
    logic [8:0] ptr = 9'h000;
    logic [7:0] tap = 8'h00;
    logic [3:0] code = 4'hf;
    logic [3:0] eff = 4'hf;
    logic [15:0] pat = 16'h0000;
    logic xfer = 1'b0;
    logic split = 1'b0;
    logic armed = 1'b0;
    always @(posedge mclk_i) pat <= pat + 16'h0001;
    // A released bus shows a moving pattern so a stale value never passes.
    assign dq_o = dq_oe_i ? dq_i : pat;
    assign half_o = ptr[8];
    always @(negedge ras_n_i) begin
        xfer = cas_n_i && !xfer_n_i && we_n_i;
        split = xfer && sel_i;
        if (!cas_n_i && sel_i && !we_n_i) code = addr_i[7:4];
        // The option reset clears the stored code too, so a later split keeps the default.
        if (!cas_n_i && !sel_i) begin
            eff = 4'hf;
            code = 4'hf;
        end
    end
    // Strobe and column address leave the host on one edge, so look just after it.
    always @(negedge cas_n_i) begin
        #1;
        if (!ras_n_i && split) begin
            tap = addr_i[7:0];
            armed = 1'b1;
            eff = code;
        end else if (!ras_n_i && xfer) begin
            ptr = addr_i;
            armed = 1'b0;
        end
    end
    always @(posedge shift_clk_i) begin
        if (armed && (ptr[7:0] & {eff, 4'hf}) == {eff, 4'hf}) begin
            ptr = {~ptr[8], tap};
            armed = 1'b0;
        end else begin
            ptr = ptr + 9'h001;
        end
    end
endmodule
`default_nettype wire

// File: vram_split_transfer_and_write_decode_tb.sv
// Purpose: Self-checking bench for the video DRAM host controller.
// Assumes: Device model on the pins; integer model of the serial pointer.
// Notes: Stop points go back to default before any split is issued.
`timescale 1ns/1ps
`default_nettype none
module vram_split_transfer_and_write_decode_tb;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic [3:0] codes [0:5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0, 4'h5};
    wire logic [31:0] rdat;
    wire logic [15:0] dq_o, dq_i;
    wire logic [8:0] addr;
    wire logic wt, ras_n, cas_n, xfer_n, we_n, sel, dq_oe, shift_clk, sen_n, half;
    integer err_count = 0;
    integer cmp_count = 0;
    integer seed = 32'ha0bbb583;
    integer i, sh, tap, armed;
    always #5 mclk_i = ~mclk_i;
    vram_host i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .transfer_output_enable_n_o(xfer_n), .write_mask_strobe_n_o(we_n),
        .special_function_select_o(sel), .addr_o(addr), .dq_o(dq_o), .dq_oe_o(dq_oe),
        .dq_i(dq_i), .serial_shift_clock_o(shift_clk), .serial_port_enable_n_o(sen_n),
        .serial_half_indicator_i(half));
    vram_dev_model i_dev (.mclk_i(mclk_i), .ras_n_i(ras_n), .cas_n_i(cas_n), .xfer_n_i(xfer_n),
        .we_n_i(we_n), .sel_i(sel), .addr_i(addr), .dq_i(dq_o), .dq_oe_i(dq_oe),
        .shift_clk_i(shift_clk), .half_o(half), .dq_o(dq_i));
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        // The request stands until the rising edge that samples waitrequest low.
        do begin
            @(posedge mclk_i);
            n++;
        end while (wt !== 1'b0 && n < 500);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (wt !== 1'b0) begin
            err_count++;
            finish_test();
        end
        @(posedge mclk_i);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic poll(input logic [4:0] a, input logic [31:0] m);
        integer n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0);
            n++;
        end while ((q & m) !== 32'h0 && n < 2000);
        if ((q & m) !== 32'h0) begin
            err_count++;
            finish_test();
        end
    endtask
    task automatic cmd(input logic [3:0] op, input logic [31:0] a);
        bus(1'b1, 5'h04, a);
        bus(1'b1, 5'h00, {28'h0, op});
        poll(5'h0c, 32'h1);
    endtask
    task automatic shift(input integer n);
        bus(1'b1, 5'h10, n);
        chk({31'h0, sen_n}, 32'h0);
        poll(5'h10, 32'hffff);
        repeat (n) begin
            if (armed && sh % 256 == 255) begin
                sh = (sh / 256 ^ 1) * 256 + tap;
                armed = 0;
            end else begin
                sh = (sh + 1) % 512;
            end
        end
    endtask
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        chk({26'h0, wt, ras_n, cas_n, xfer_n, we_n, dq_oe}, 32'h3e);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        rd_chk(5'h18, 32'h0);
        cmd(4'h1, 32'h0);
        rd_chk(5'h0c, 32'h8);
        $display("test reset and refusal done");
        for (i = 0; i < 6; i++) begin
            bus(1'b1, 5'h0c, 32'h8);
            cmd(4'h2, {24'h0, codes[i], 4'h0});
            rd_chk(5'h0c, {28'h0, codes[i] == 4'h5, 3'h0});
        end
        cmd(4'h3, 32'h0);
        bus(1'b1, 5'h0c, 32'h8);
        $display("test stop codes done");
        for (i = 4; i < 11; i++) begin
            bus(1'b1, 5'h08, $random(seed));
            bus(1'b1, 5'h14, $random(seed));
            cmd(i[3:0], $random(seed) & 32'h01ff01ff);
            rd_chk(5'h0c, 32'h0);
        end
        $display("test write decode done");
        sh = 9'h1f0;
        armed = 0;
        cmd(4'h0, 32'h01f00000 | $random(seed) & 32'h1ff);
        rd_chk(5'h0c, 32'h6);
        shift(32);
        rd_chk(5'h10, sh << 16);
        rd_chk(5'h0c, 32'h4);
        chk({31'h0, sen_n}, 32'h1);
        $display("test wrap done");
        for (i = 0; i < 4; i++) begin
            sh = $unsigned($random(seed)) % 192 + 32 + ($random(seed) & 256);
            cmd(4'h0, sh << 16);
            tap = $unsigned($random(seed)) % 256;
            cmd(4'h1, (tap + 256) << 16);
            tap = $unsigned($random(seed)) % 256;
            cmd(4'h1, tap << 16);
            armed = 1;
            rd_chk(5'h0c, 4 + sh / 256 * 2);
            shift(272 - sh % 256);
            rd_chk(5'h10, sh << 16);
            rd_chk(5'h0c, 4 + sh / 256 * 2);
        end
        $display("test split done");
        finish_test();
    end
endmodule
bind vram_host vram_host_monitor #(.SHIFT_HALF(SHIFT_HALF)) i_mon (.mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .avs_waitrequest_o(avs_waitrequest_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o),
    .transfer_output_enable_n_o(transfer_output_enable_n_o),
    .write_mask_strobe_n_o(write_mask_strobe_n_o), .addr_o(addr_o), .dq_oe_o(dq_oe_o),
    .special_function_select_o(special_function_select_o),
    .serial_shift_clock_o(serial_shift_clock_o));
`default_nettype wire
